// ### adc_pkg.sv
// Overview of operation
// - converter runs only while enable bit 15 is one
// - idle_stop bit 13 halts the converter while device idle is asserted
// - format 000: result right-justified in bits 9..0, rest zero
// - format 010: result in bits 15..6, all other bits zero
// - format 011: signed fraction, sign bit 15, data to bit 6
// - format 100: unsigned result in bits 9..0, bits 31..10 zero
// - format 101: signed result, sign replicated from bit 9 to 31
// - format 110: unsigned result in bits 31..22, lower bits zero
// - format 111: signed fraction, sign bit 31, data to bit 22
// - trigger 000: software clearing sample_active starts conversion
// - trigger 001: active edge on external irq zero pin starts conversion
// - trigger 010: timer three period match starts conversion
// - trigger 011: charge time measure unit trigger starts conversion
// - trigger 111: internal sample counter starts conversion; 100..110 reserved
// - auto sample off: software sets sample_active; on: hardware sets it
// - nonzero trigger: hardware clears sample_active; zero: software clears it
// - completion flag bit 0 set by hardware when conversion finishes
// - software clears completion flag with zero; clearing leaves conversion alone
// - completion flag cleared by hardware when new conversion begins
package adc_pkg;
  localparam logic [11:0] ADC_CONTROL_ONE_OFS = 12'h000;
  localparam logic [11:0] ADC_RESULT_OFS      = 12'h004;
  localparam logic [11:0] ADC_STATUS_OFS      = 12'h008;
  localparam int          EN_BIT              = 15;
  localparam int          IDLE_STOP_BIT       = 13;
  localparam int          OUTPUT_FORMAT_LSB            = 8;
  localparam int          TRIG_LSB            = 5;
  localparam int          STOP_AUTO_BIT       = 4;
  localparam int          AUTO_SAMPLE_BIT     = 2;
  localparam int          SAMPLE_BIT          = 1;
  localparam int          DONE_BIT            = 0;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK          = 32'h0000_a7f7;
  localparam logic [2:0]  FMT_INT16           = 3'h0;
  localparam logic [2:0]  FMT_FRAC16          = 3'h2;
  localparam logic [2:0]  FMT_SFRAC16         = 3'h3;
  localparam logic [2:0]  FMT_INT32           = 3'h4;
  localparam logic [2:0]  FMT_SINT32          = 3'h5;
  localparam logic [2:0]  FMT_FRAC32          = 3'h6;
  localparam logic [2:0]  FMT_SFRAC32         = 3'h7;
  localparam logic [2:0]  TRIG_MANUAL         = 3'h0;
  localparam logic [2:0]  TRIG_EXT_IRQ        = 3'h1;
  localparam logic [2:0]  TRIG_TIMER3         = 3'h2;
  localparam logic [2:0]  TRIG_CHARGE_UNIT    = 3'h3;
  localparam logic [2:0]  TRIG_AUTO           = 3'h7;
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;
  localparam int          AUTO_SAMPLE_CYCLES  = 16;
  localparam int          CONV_CYCLES         = 12;

  typedef struct packed {
    logic       start;
    logic [9:0] data;
  } adc_core_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adc_state_t;
endpackage : adc_pkg

// ### adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
  import adc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = AUTO_SAMPLE_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        device_idle,
  input  wire logic        ext_irq_zero_pin,
  input  wire logic        ext_irq_rising,
  input  wire logic        timer3_match,
  input  wire logic        charge_unit_trigger,
  output var  logic        core_sample,
  output var  adc_core_t   core_cmd,
  input  wire logic        core_done,
  input  wire logic [9:0]  core_result,
  output var  logic [31:0] result_word,
  output var  logic        conv_done_pulse
);

  //////////////////////////////////////////////////////////////////////////////
  // register fields

  logic [31:0] ctrl;
  logic        en;
  logic        idle_stop;
  logic [2:0]  output_format;
  logic [2:0]  trigger_source_select;
  logic        stop_auto_sample;
  logic        auto_sample_enable;
  logic        sample_active;
  logic        done_flag;
  logic        running;
  adc_state_t  state;
  logic [15:0] cnt;
  logic        irq_q;
  logic        irq_edge;
  logic        trig_hit;
  logic        conv_start;
  logic        conv_end;

  assign en                    = ctrl[EN_BIT];
  assign idle_stop             = ctrl[IDLE_STOP_BIT];
  assign output_format         = ctrl[OUTPUT_FORMAT_LSB +: 3];
  assign trigger_source_select = ctrl[TRIG_LSB +: 3];
  assign stop_auto_sample      = ctrl[STOP_AUTO_BIT];
  assign auto_sample_enable    = ctrl[AUTO_SAMPLE_BIT];
  assign running               = en && !(idle_stop && device_idle);

  function automatic logic [31:0] fmt_word(input logic [2:0] f, input logic [9:0] d);
    logic [9:0] s;
    s = {~d[9], d[8:0]};
    case (f)
      FMT_INT16:   fmt_word = {22'h0, d};
      FMT_FRAC16:  fmt_word = {16'h0, d, 6'h0};
      FMT_SFRAC16: fmt_word = {16'h0, s, 6'h0};
      FMT_INT32:   fmt_word = {22'h0, d};
      FMT_SINT32:  fmt_word = {{23{s[9]}}, s[8:0]};
      FMT_FRAC32:  fmt_word = {d, 22'h0};
      FMT_SFRAC32: fmt_word = {s, 22'h0};
      default:     fmt_word = {22'h0, d};
    endcase
  endfunction : fmt_word

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] wr_val;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wmask   = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_val  = (ctrl & ~wmask) | (w_data & wmask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[11:2] == ADC_CONTROL_ONE_OFS[11:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr[11:2])
          ADC_CONTROL_ONE_OFS[11:2]: s_axi_rdata <= ctrl;
          ADC_RESULT_OFS[11:2]:      s_axi_rdata <= result_word;
          ADC_STATUS_OFS[11:2]:      s_axi_rdata <= {29'h0, running, state == ST_CONVERT, state == ST_SAMPLE};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger detection

  assign irq_edge = ext_irq_rising ? (ext_irq_zero_pin && !irq_q) : (!ext_irq_zero_pin && irq_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= ext_irq_zero_pin;
  end

  always_comb
  begin
    case (trigger_source_select)
      TRIG_EXT_IRQ:   trig_hit = irq_edge;
      TRIG_TIMER3:    trig_hit = timer3_match;
      TRIG_CHARGE_UNIT: trig_hit = charge_unit_trigger;
      TRIG_AUTO:      trig_hit = (cnt == 16'(SAMPLE_CYCLES - 1));
      default:        trig_hit = 1'b0;
    endcase
  end

  // manual mode: software writing zero to sample_active ends sampling
  assign conv_start = (state == ST_SAMPLE) && running &&
                      ((trigger_source_select == TRIG_MANUAL) ? !sample_active : trig_hit);
  assign conv_end   = (state == ST_CONVERT) && core_done;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_OFF;
      cnt   <= 16'h0000;
    end
    else if (!running)
    begin
      state <= ST_OFF;
      cnt   <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_OFF:     state <= ST_IDLE;
        ST_IDLE:
        begin
          cnt <= 16'h0000;
          if (sample_active)
            state <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          cnt <= cnt + 16'h0001;
          if (conv_start)
            state <= ST_CONVERT;
        end
        ST_CONVERT:
        begin
          if (conv_end)
            state <= ST_IDLE;
        end
        default:    state <= ST_OFF;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register with hardware-owned bits

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= CTRL_RESET;
    else
    begin
      // clear first so a write that sets enable may also start sampling
      if (!en)
        ctrl[SAMPLE_BIT] <= 1'b0;
      if (wr_fire && aw_addr[11:2] == ADC_CONTROL_ONE_OFS[11:2])
      begin
        ctrl <= wr_val & CTRL_WMASK;
        // software can only clear done; a written one keeps the old value
        ctrl[DONE_BIT] <= ctrl[DONE_BIT] & wr_val[DONE_BIT];
      end
      if (conv_start)
      begin
        ctrl[SAMPLE_BIT] <= 1'b0;
        ctrl[DONE_BIT]   <= 1'b0;
      end
      if (conv_end)
      begin
        ctrl[DONE_BIT] <= 1'b1;
        if (auto_sample_enable && !stop_auto_sample)
          ctrl[SAMPLE_BIT] <= 1'b1;
        if (stop_auto_sample)
          ctrl[AUTO_SAMPLE_BIT] <= 1'b0;
      end
      else if (auto_sample_enable && running && state == ST_IDLE)
        ctrl[SAMPLE_BIT] <= 1'b1;
    end
  end

  assign sample_active = ctrl[SAMPLE_BIT];
  assign done_flag     = ctrl[DONE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // core drive and result

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_sample     <= 1'b0;
      core_cmd        <= '0;
      result_word     <= 32'h0000_0000;
      conv_done_pulse <= 1'b0;
    end
    else
    begin
      core_sample     <= running && state == ST_SAMPLE && !conv_start;
      core_cmd.start  <= conv_start;
      core_cmd.data   <= 10'h000;
      conv_done_pulse <= conv_end;
      if (conv_end)
        result_word <= fmt_word(output_format, core_result);
    end
  end

endmodule : adc_ctrl
`default_nettype wire

// ### adc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props
  import adc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = AUTO_SAMPLE_CYCLES
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        core_sample,
  input wire adc_core_t   core_cmd,
  input wire logic        core_done,
  input wire logic [31:0] result_word,
  input wire logic        conv_done_pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_done_src;
    conv_done_pulse |-> $past(core_done);
  endproperty
  a_done_src: assert property (p_done_src)
    else $error("done pulse without core completion");
  property p_done_one;
    conv_done_pulse |=> !conv_done_pulse;
  endproperty
  a_done_one: assert property (p_done_one)
    else $error("done pulse longer than one cycle");
  property p_start_one;
    core_cmd.start |=> !core_cmd.start;
  endproperty
  a_start_one: assert property (p_start_one)
    else $error("start pulse longer than one cycle");
  property p_start_ends;
    core_cmd.start |-> !core_sample && $past(core_sample);
  endproperty
  a_start_ends: assert property (p_start_ends)
    else $error("start not at end of sampling");
  property p_conv_quiet;
    core_cmd.start |=> !core_sample [*3];
  endproperty
  a_conv_quiet: assert property (p_conv_quiet)
    else $error("sampling reopened during conversion");
  property p_word_hold;
    conv_done_pulse |=> $stable(result_word) [*3];
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("result word changed without conversion");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped early");
endmodule : adc_ctrl_props
`default_nettype wire

// ### adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model
  import adc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire adc_core_t  core_cmd,
  input  wire logic [9:0] code,
  input  wire logic [3:0] lat,
  output var  logic       core_done,
  output var  logic [9:0] core_result
);
  int cnt;
  // result valid only beside done, scrambled otherwise
  always @(posedge aclk)
    if (!aresetn)
    begin
      cnt <= 0;
      core_done <= 1'b0;
      core_result <= 10'h155;
    end
    else
    begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (core_cmd.start)
        cnt <= lat;
      else if (cnt == 1)
      begin
        cnt <= 0;
        core_done <= 1'b1;
        core_result <= code;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
endmodule : adc_core_model
`default_nettype wire

// ### tb_adc_sample_convert_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sample_convert_control
  import adc_pkg::*;
;
  localparam logic [11:0] CT = ADC_CONTROL_ONE_OFS;
  localparam logic [31:0] ON = 32'h1 << EN_BIT;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, result_word;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, device_idle = 1'b0;
  logic        ext_irq_zero_pin = 1'b0, timer3_match = 1'b0, charge_unit_trigger = 1'b0;
  logic        ext_irq_rising = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        core_sample, core_done, conv_done_pulse;
  adc_core_t   core_cmd;
  logic [9:0]  core_result, code = 10'h000;
  logic [3:0]  lat = 4'hc;
  logic [2:0]  fl [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int          n_mismatch = 0, num_checks = 0;
  always #2.5 aclk = ~aclk;
  adc_ctrl #(.SAMPLE_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .device_idle, .ext_irq_zero_pin, .ext_irq_rising, .timer3_match, .charge_unit_trigger,
    .core_sample, .core_cmd, .core_done, .core_result, .result_word, .conv_done_pulse);
  adc_core_model core_u (.aclk, .aresetn, .core_cmd, .code, .lat, .core_done, .core_result);
  ////////////////////////////////////////
  function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] c);
    case (f)
      3'h2: fmt = {16'h0, c, 6'h0};
      3'h3: fmt = {16'h0, ~c[9], c[8:0], 6'h0};
      3'h5: fmt = {{23{~c[9]}}, c[8:0]};
      3'h6: fmt = {c, 22'h0};
      3'h7: fmt = {~c[9], c[8:0], 22'h0};
      default: fmt = {22'h0, c};
    endcase
  endfunction : fmt
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk("bresp", {30'h0, ((a == CT) ? RESP_OKAY : RESP_SLVERR)}, {30'h0, r});
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                    input string n);
    logic [31:0] d;
    logic [1:0]  r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk(n, e, d);
    chk(n, {30'h0, er}, {30'h0, r});
  endtask : rc
  task automatic wt(ref logic s, input string n);
    int i;
    i = 0;
    do
    begin
      @(posedge aclk);
      i++;
    end
    while (!s && i < 300);
    chk(n, 32'h1, {31'h0, s});
  endtask : wt
  task automatic ev(input logic [2:0] m);
    {ext_irq_zero_pin, timer3_match, charge_unit_trigger} <= m;
    @(posedge aclk);
    {ext_irq_zero_pin, timer3_match, charge_unit_trigger} <= 3'h0;
    @(posedge aclk);
  endtask : ev
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  initial
  begin
    #100us;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    logic [31:0] c;
    int          k;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(12'h00c, 32'hffff_ffff);
    rc(CT, CTRL_RESET, RESP_OKAY, "ctrl_reset");
    rc(12'h00c, 32'h0, RESP_SLVERR, "unmapped");
    for (int i = 0; i < 7; i++)
    begin
      code <= i[0] ? 10'h2c5 : 10'h13a;
      c = ON | (32'(fl[i]) << OUTPUT_FORMAT_LSB);
      wr(CT, c | 32'h3);
      wr(CT, c | 32'h1);
      rc(CT, c, RESP_OKAY, "ctrl_started");
      wt(conv_done_pulse, "done_pulse");
      chk("result_word", fmt(fl[i], code), result_word);
      rc(ADC_RESULT_OFS, fmt(fl[i], code), RESP_OKAY, "result_reg");
      rc(CT, c | 32'h1, RESP_OKAY, "ctrl_done");
    end
    device_idle <= 1'b1;
    for (int t = 1; t < 5; t++)
    begin
      k = (t == 4) ? 1 : t;
      ext_irq_rising <= (t != 4);
      c = ON | (32'(k) << TRIG_LSB);
      wr(CT, c | 32'h2);
      ev(~(3'h4 >> (k - 1)));
      chk("sampling_held", 32'h1, {31'h0, core_sample});
      ev(3'h4 >> (k - 1));
      wr(CT, c);
      wt(conv_done_pulse, "trig_done");
      rc(CT, c | 32'h1, RESP_OKAY, "ctrl_trig");
    end
    lat <= 4'h4;
    c = ON | (32'(TRIG_AUTO) << TRIG_LSB) | 32'h4;
    wr(CT, c);
    repeat (2) wt(conv_done_pulse, "auto_done");
    wr(CT, c | 32'h10);
    wt(conv_done_pulse, "last_done");
    rc(CT, c ^ 32'h15, RESP_OKAY, "ctrl_stop");
    repeat (20) @(posedge aclk);
    chk("sample_stopped", 32'h0, {31'h0, core_sample});
    wr(CT, c | 32'h2000);
    repeat (20) @(posedge aclk);
    chk("idle_halt", 32'h0, {31'h0, core_sample});
    rc(ADC_STATUS_OFS, 32'h0, RESP_OKAY, "status_halt");
    device_idle <= 1'b0;
    wt(core_sample, "idle_resume");
    rc(ADC_STATUS_OFS, 32'h5, RESP_OKAY, "status_sample");
    wr(CT, 32'h0);
    @(posedge aclk);
    repeat (20) @(posedge aclk);
    chk("disabled", 32'h0, {31'h0, core_sample});
    conclude();
  end
endmodule : tb_adc_sample_convert_control
bind adc_ctrl adc_ctrl_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_props (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .core_sample, .core_cmd, .core_done, .result_word, .conv_done_pulse);
`default_nettype wire
